// ===== design/mpsq_pkg.sv
/*
  constants and types shared by both ends of the power-off / reset sequencer.
  assumes a single 40 mhz clock on both ends.
*/
package mpsq_pkg;
  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 40000000;
  localparam int unsigned KEY_MIN_CYCLES = 16;     // least power key low width
  localparam int unsigned RESET_MIN_CYCLES = 32;   // hard reset low width for reboot
  localparam int unsigned SAVE_CYCLES = 24;        // parameter save phase
  localparam int unsigned DETACH_CYCLES = 24;      // network detach phase
  localparam int unsigned BOOT_CYCLES = 20;        // switch-on sequence length
  localparam int unsigned HOST_TIMEOUT = 256;      // host wait for an answer
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // ---------------------------------------------------------------
  // command codes on the command channel
  // ---------------------------------------------------------------
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SWITCH_OFF = 2'h1;
  localparam logic [1:0] CMD_REBOOT = 2'h2;
  localparam logic [1:0] CMD_THERMAL = 2'h3;

  // ---------------------------------------------------------------
  // device states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_OFF = 3'h0,
    DEV_BOOT = 3'h1,
    DEV_RUN = 3'h2,
    DEV_SAVE = 3'h3,
    DEV_DETACH = 3'h4,
    DEV_DOWN = 3'h5
  } mpsq_dev_e;
endpackage

// ===== design/mpsq_link_if.sv
/*
  link between host and device: pins plus the command channel.
  assumes both ends share i_clock; pull-ups resolve here.
*/
interface mpsq_link_if;
  // pins driven by the host: key and reset as open drain, plus main supply
  logic power_key_oe;   // high: host pulls power key low
  logic hard_reset_oe;  // high: host pulls hard reset low
  logic main_supply;    // host applies main supply
  // pins driven by the device
  logic interface_supply;
  logic backup_supply;
  logic digital_oe;     // digital pins driven, low means tri-stated
  // command channel
  logic cmd_valid;
  logic [1:0] cmd_code;
  logic cmd_arg;        // thermal supervision enable
  logic cmd_ready;
  logic rsp_ok;         // one-cycle ok answer

  // resolved pin levels: internal pull-ups hold them high
  logic power_key_n;
  logic hard_reset_n;
  assign power_key_n = ~power_key_oe;
  assign hard_reset_n = ~hard_reset_oe;

  modport dev (
    input power_key_n, hard_reset_n, main_supply, cmd_valid, cmd_code, cmd_arg,
    output interface_supply, backup_supply, digital_oe, cmd_ready, rsp_ok
  );
  modport host (
    input interface_supply, backup_supply, cmd_ready, rsp_ok,
    output power_key_oe, hard_reset_oe, main_supply, cmd_valid, cmd_code, cmd_arg
  );
endinterface

// ===== design/mpsq_sync.sv
/*
  three-stage synchroniser with agreement filter for pin inputs.
  assumes the input is asynchronous to i_clock.
*/
module mpsq_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // pin in, filtered level out
  input wire logic i_pin,
  output logic o_level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } mpsq_sync_s;

  mpsq_sync_s cur_ff;
  mpsq_sync_s nxt_cur;

  // level changes only when stages two and three agree
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.stage = {cur_ff.stage[1:0], i_pin};
    if (cur_ff.stage[1] == cur_ff.stage[2]) begin
      nxt_cur.level = cur_ff.stage[2];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_ff <= '{stage: {3{RST_VAL}}, level: RST_VAL};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_level = cur_ff.level;
endmodule

// ===== design/mpsq_device.sv
/*
  device end: power-off, reset and switch-on sequencing of the module.
  assumes the host end keeps main supply until interface supply is low.
*/
// Overview of operation
// [R1] switch-off command saves settings, detaches, powers down
// [R2] ok answered while switch-off routine runs
// [R3] valid power key pulse: switch-off on release
// [R4] routine end: tri-state pins, regulators off, backup on
// [R5] stay off until switch-on event or supply loss
// [R6] host keeps supply until interface supply low
// [R7] host watches interface supply for completion
// [R8] supply loss: abrupt shutdown, no save, no detach
// [R9] hard reset low: abrupt shutdown, no save; in DEV_BOOT the code holds boot until release instead
// [R10] hard reset held long: abrupt hardware reset
// [R11] host uses hard reset only after command failure
// [R12] host prefers switch-off command over supply removal
// [R13] reboot command: save, detach, then internal reset
// [R14] pins pulled high when host leaves them
// [R15] enabled thermal supervision shuts down on danger
// [R16] from off, release of key or reset boots
// [R17] power key width minimum, shorter pulses ignored
module mpsq_device (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // pins and commands
  mpsq_link_if.dev link,
  // user side: temperature monitor
  input wire logic i_temp_danger,
  // user side: status
  output logic o_running,
  output logic o_saving,
  output logic o_detaching,
  output logic o_reboot_pulse,
  output logic o_abrupt_pulse
);
  typedef struct packed {
    mpsq_pkg::mpsq_dev_e state;
    logic [mpsq_pkg::CNT_W-1:0] cnt;
    logic [mpsq_pkg::CNT_W-1:0] key_cnt;
    logic [mpsq_pkg::CNT_W-1:0] rst_cnt;
    logic key_armed;
    logic rst_armed;
    logic reboot;
    logic thermal_en;
    logic rsp_ok;
    logic reboot_pulse;
    logic abrupt_pulse;
  } mpsq_dev_s;

  mpsq_dev_s cur_ff;
  mpsq_dev_s nxt_cur;
  logic key_n;
  logic rst_n;
  logic supply;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // pull-ups sit in the interface; reset value high matches them
  mpsq_sync #(.RST_VAL(1'b1)) u_key (
    .i_clock(i_clock), .i_srst(i_srst), .i_pin(link.power_key_n), .o_level(key_n)
  ); // R14
  mpsq_sync #(.RST_VAL(1'b1)) u_rst (
    .i_clock(i_clock), .i_srst(i_srst), .i_pin(link.hard_reset_n), .o_level(rst_n)
  ); // R14
  mpsq_sync #(.RST_VAL(1'b0)) u_sup (
    .i_clock(i_clock), .i_srst(i_srst), .i_pin(link.main_supply), .o_level(supply)
  );

  function automatic logic [mpsq_pkg::CNT_W-1:0] sat_inc(input logic [mpsq_pkg::CNT_W-1:0] v);
    sat_inc = (v == 16'hffff) ? v : v + mpsq_pkg::CNT_ONE;
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp_ok = 1'b0;
    nxt_cur.reboot_pulse = 1'b0;
    nxt_cur.abrupt_pulse = 1'b0;
    // key and reset low-width counters; key armed once wide enough, reset armed while low
    nxt_cur.key_cnt = key_n ? mpsq_pkg::CNT_ZERO : sat_inc(cur_ff.key_cnt);
    nxt_cur.rst_cnt = rst_n ? mpsq_pkg::CNT_ZERO : sat_inc(cur_ff.rst_cnt);
    if (!key_n && cur_ff.key_cnt >= 16'(mpsq_pkg::KEY_MIN_CYCLES - 1)) begin
      nxt_cur.key_armed = 1'b1; // R17
    end
    if (!rst_n) begin
      nxt_cur.rst_armed = 1'b1;
    end
    if (cur_ff.cnt != mpsq_pkg::CNT_ZERO) begin
      nxt_cur.cnt = cur_ff.cnt - mpsq_pkg::CNT_ONE;
    end
    unique case (cur_ff.state)
      mpsq_pkg::DEV_OFF: begin
        // released key after a valid pulse, or released reset
        if (supply && key_n && cur_ff.key_armed) begin
          nxt_cur.state = mpsq_pkg::DEV_BOOT; // R16
          nxt_cur.cnt = 16'(mpsq_pkg::BOOT_CYCLES);
        end else if (supply && rst_n && cur_ff.rst_armed) begin
          nxt_cur.state = mpsq_pkg::DEV_BOOT; // R16
          nxt_cur.cnt = 16'(mpsq_pkg::BOOT_CYCLES);
        end // R5
        if (key_n) begin
          nxt_cur.key_armed = 1'b0;
        end
        if (rst_n) begin
          nxt_cur.rst_armed = 1'b0;
        end
      end
      mpsq_pkg::DEV_BOOT: begin
        if (cur_ff.cnt == mpsq_pkg::CNT_ZERO && rst_n) begin
          nxt_cur.state = mpsq_pkg::DEV_RUN;
          nxt_cur.key_armed = 1'b0;
          nxt_cur.rst_armed = 1'b0;
        end
      end
      mpsq_pkg::DEV_RUN: begin
        if (link.cmd_valid && link.cmd_code == mpsq_pkg::CMD_SWITCH_OFF) begin
          nxt_cur.state = mpsq_pkg::DEV_SAVE; // R1
          nxt_cur.cnt = 16'(mpsq_pkg::SAVE_CYCLES);
          nxt_cur.reboot = 1'b0;
          nxt_cur.rsp_ok = 1'b1; // R2
        end else if (link.cmd_valid && link.cmd_code == mpsq_pkg::CMD_REBOOT) begin
          nxt_cur.state = mpsq_pkg::DEV_SAVE; // R13
          nxt_cur.cnt = 16'(mpsq_pkg::SAVE_CYCLES);
          nxt_cur.reboot = 1'b1;
          nxt_cur.rsp_ok = 1'b1;
        end else if (link.cmd_valid && link.cmd_code == mpsq_pkg::CMD_THERMAL) begin
          nxt_cur.thermal_en = link.cmd_arg;
          nxt_cur.rsp_ok = 1'b1;
        end else if (key_n && cur_ff.key_armed) begin
          nxt_cur.state = mpsq_pkg::DEV_SAVE; // R3
          nxt_cur.cnt = 16'(mpsq_pkg::SAVE_CYCLES);
          nxt_cur.reboot = 1'b0;
        end else if (cur_ff.thermal_en && i_temp_danger) begin
          nxt_cur.state = mpsq_pkg::DEV_SAVE; // R15
          nxt_cur.cnt = 16'(mpsq_pkg::SAVE_CYCLES);
          nxt_cur.reboot = 1'b0;
        end
        if (key_n) begin
          nxt_cur.key_armed = 1'b0;
        end
      end
      mpsq_pkg::DEV_SAVE: begin
        if (cur_ff.cnt == mpsq_pkg::CNT_ZERO) begin
          nxt_cur.state = mpsq_pkg::DEV_DETACH; // R1
          nxt_cur.cnt = 16'(mpsq_pkg::DETACH_CYCLES);
        end
      end
      mpsq_pkg::DEV_DETACH: begin
        if (cur_ff.cnt == mpsq_pkg::CNT_ZERO) begin
          nxt_cur.state = cur_ff.reboot ? mpsq_pkg::DEV_BOOT : mpsq_pkg::DEV_DOWN; // R13
          nxt_cur.cnt = 16'(mpsq_pkg::BOOT_CYCLES);
          nxt_cur.reboot_pulse = cur_ff.reboot;
        end
      end
      mpsq_pkg::DEV_DOWN: begin
        nxt_cur.state = mpsq_pkg::DEV_OFF; // R4
        nxt_cur.key_armed = 1'b0;
        nxt_cur.rst_armed = 1'b0;
      end
      default: begin
        nxt_cur.state = mpsq_pkg::DEV_OFF;
      end
    endcase
    // abrupt paths override next state and ok answer outside off and down, nothing saved or detached
    if (cur_ff.state != mpsq_pkg::DEV_OFF && cur_ff.state != mpsq_pkg::DEV_DOWN) begin
      if (!supply) begin
        nxt_cur.state = mpsq_pkg::DEV_OFF; // R8
        nxt_cur.abrupt_pulse = 1'b1;
        nxt_cur.rsp_ok = 1'b0;
      end else if (!rst_n && cur_ff.state != mpsq_pkg::DEV_BOOT) begin
        // shutdown now; if still low in the second off cycle the release reboots it
        nxt_cur.state = mpsq_pkg::DEV_OFF; // R9
        nxt_cur.abrupt_pulse = 1'b1;
        nxt_cur.rsp_ok = 1'b0;
        nxt_cur.rst_armed = 1'b0;
      end
    end
    // long hard reset re-arms the switch-on from off
    if (cur_ff.state == mpsq_pkg::DEV_OFF && !rst_n &&
        cur_ff.rst_cnt >= 16'(mpsq_pkg::RESET_MIN_CYCLES - 1)) begin
      nxt_cur.rst_armed = 1'b1; // R10
    end
    // the first off cycle after an abrupt stop clears arming by a short reset
    if (cur_ff.state == mpsq_pkg::DEV_OFF && !rst_n &&
        cur_ff.rst_cnt < 16'(mpsq_pkg::RESET_MIN_CYCLES - 1) && cur_ff.abrupt_pulse) begin
      nxt_cur.rst_armed = 1'b0; // R9
    end
    if (!supply) begin
      nxt_cur.key_armed = 1'b0; // R5
      nxt_cur.rst_armed = 1'b0;
      nxt_cur.thermal_en = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // interface supply up in every state except off and down
  assign link.interface_supply = cur_ff.state != mpsq_pkg::DEV_OFF &&
                                 cur_ff.state != mpsq_pkg::DEV_DOWN; // R4
  assign link.digital_oe = cur_ff.state == mpsq_pkg::DEV_RUN ||
                           cur_ff.state == mpsq_pkg::DEV_SAVE ||
                           cur_ff.state == mpsq_pkg::DEV_DETACH; // R4
  assign link.backup_supply = supply; // R4
  assign link.cmd_ready = cur_ff.state == mpsq_pkg::DEV_RUN;
  assign link.rsp_ok = cur_ff.rsp_ok;
  assign o_running = cur_ff.state == mpsq_pkg::DEV_RUN;
  assign o_saving = cur_ff.state == mpsq_pkg::DEV_SAVE;
  assign o_detaching = cur_ff.state == mpsq_pkg::DEV_DETACH;
  assign o_reboot_pulse = cur_ff.reboot_pulse;
  assign o_abrupt_pulse = cur_ff.abrupt_pulse;
endmodule

// ===== design/mpsq_host.sv
/*
  host end: drives power key, hard reset, main supply and commands.
  assumes the device end answers as in mpsq_device.
*/
module mpsq_host (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // pins and commands
  mpsq_link_if.host link,
  // user side requests, one-cycle pulses; i_thermal_en is a level read with i_thermal_set
  input wire logic i_supply_on,
  input wire logic i_switch_off,
  input wire logic i_reboot,
  input wire logic i_key_pulse,
  input wire logic i_thermal_set,
  input wire logic i_thermal_en,
  // user side status
  output logic o_busy,
  output logic o_supply,
  output logic o_device_up,
  output logic o_forced_reset
);
  typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_CMD = 3'h1,
    HST_WAIT_OK = 3'h2,
    HST_WAIT_LOW = 3'h3,
    HST_KEY = 3'h4,
    HST_HRST = 3'h5
  } mpsq_hst_e;

  typedef struct packed {
    mpsq_hst_e state;
    logic [mpsq_pkg::CNT_W-1:0] cnt;
    logic [1:0] code;
    logic arg;
    logic supply;
    logic forced;
  } mpsq_hst_s;

  mpsq_hst_s cur_ff;
  mpsq_hst_s nxt_cur;
  logic vint;

  // interface supply is a pin seen through the filter
  mpsq_sync #(.RST_VAL(1'b0)) u_vint (
    .i_clock(i_clock), .i_srst(i_srst), .i_pin(link.interface_supply), .o_level(vint)
  );

  // ---------------------------------------------------------------
  // host sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.forced = 1'b0;
    if (cur_ff.cnt != mpsq_pkg::CNT_ZERO) begin
      nxt_cur.cnt = cur_ff.cnt - mpsq_pkg::CNT_ONE;
    end
    unique case (cur_ff.state)
      HST_IDLE: begin
        if (i_supply_on) begin
          nxt_cur.supply = 1'b1;
        end else if (i_switch_off && vint) begin
          nxt_cur.state = HST_CMD; // R12
          nxt_cur.code = mpsq_pkg::CMD_SWITCH_OFF;
        end else if (i_reboot && vint) begin
          nxt_cur.state = HST_CMD;
          nxt_cur.code = mpsq_pkg::CMD_REBOOT;
        end else if (i_thermal_set && vint) begin
          nxt_cur.state = HST_CMD;
          nxt_cur.code = mpsq_pkg::CMD_THERMAL;
          nxt_cur.arg = i_thermal_en;
        end else if (i_key_pulse && cur_ff.supply) begin
          nxt_cur.state = HST_KEY; // R17
          nxt_cur.cnt = 16'(mpsq_pkg::KEY_MIN_CYCLES + 4);
        end
      end
      HST_CMD: begin
        if (link.cmd_ready) begin
          nxt_cur.state = HST_WAIT_OK;
          nxt_cur.cnt = 16'(mpsq_pkg::HOST_TIMEOUT);
        end
      end
      HST_WAIT_OK: begin
        if (link.rsp_ok) begin
          nxt_cur.state = (cur_ff.code == mpsq_pkg::CMD_SWITCH_OFF) ? HST_WAIT_LOW : HST_IDLE;
          nxt_cur.cnt = 16'hffff;
        end else if (cur_ff.cnt == mpsq_pkg::CNT_ZERO) begin
          // no answer in time: fall back to hard reset
          nxt_cur.state = HST_HRST; // R11
          nxt_cur.cnt = 16'(mpsq_pkg::RESET_MIN_CYCLES + 4);
          nxt_cur.forced = 1'b1;
        end
      end
      HST_WAIT_LOW: begin
        if (!vint) begin
          nxt_cur.supply = 1'b0; // R6 R7
          nxt_cur.state = HST_IDLE;
        end else if (cur_ff.cnt == mpsq_pkg::CNT_ZERO) begin
          nxt_cur.state = HST_HRST; // R11
          nxt_cur.cnt = 16'(mpsq_pkg::RESET_MIN_CYCLES + 4);
          nxt_cur.forced = 1'b1;
        end
      end
      HST_KEY, HST_HRST: begin
        if (cur_ff.cnt == mpsq_pkg::CNT_ZERO) begin
          nxt_cur.state = HST_IDLE;
        end
      end
      default: begin
        nxt_cur.state = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.power_key_oe = cur_ff.state == HST_KEY;
  assign link.hard_reset_oe = cur_ff.state == HST_HRST; // R11
  assign link.main_supply = cur_ff.supply; // R6
  assign link.cmd_valid = cur_ff.state == HST_CMD;
  assign link.cmd_code = cur_ff.state == HST_CMD ? cur_ff.code : mpsq_pkg::CMD_NONE;
  assign link.cmd_arg = cur_ff.arg;
  assign o_busy = cur_ff.state != HST_IDLE;
  assign o_supply = cur_ff.supply;
  assign o_device_up = vint;
  assign o_forced_reset = cur_ff.forced;
endmodule

// ===== verif/mpsq_link_properties.sv
/*
  assertions on the link between host end and device end.
  assumes one clock, synchronous active-high reset, instanced beside the link.
*/
module mpsq_link_properties (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // link signals
  input wire logic power_key_n,
  input wire logic hard_reset_n,
  input wire logic main_supply,
  input wire logic interface_supply,
  input wire logic backup_supply,
  input wire logic digital_oe,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic cmd_ready,
  input wire logic rsp_ok
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  logic [7:0] key_cnt_ff;
  logic take_off;
  logic take_reboot;

  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  // raw key low width, saturating so a stuck key cannot wrap
  always_ff @(posedge i_clock) begin
    if (i_srst || power_key_n) begin
      key_cnt_ff <= 8'h00;
    end else if (key_cnt_ff != 8'hff) begin
      key_cnt_ff <= key_cnt_ff + 8'h01;
    end
  end
  // commands taken by the device
  assign take_off = cmd_valid && cmd_ready && (cmd_code == mpsq_pkg::CMD_SWITCH_OFF);
  assign take_reboot = cmd_valid && cmd_ready && (cmd_code == mpsq_pkg::CMD_REBOOT);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ok_after_take: assert property (take_off |=> rsp_ok)
    else $error("no ok answer after switch-off command");
  a_ok_one_cycle: assert property (rsp_ok |=> !rsp_ok)
    else $error("ok answer longer than one cycle");
  a_off_routine_len: assert property (take_off |-> ##45 interface_supply ##[1:20] !interface_supply)
    else $error("switch-off skipped save or detach, or never ended");
  a_reboot_saves_first: assert property (take_reboot |-> ##45 (interface_supply && !cmd_ready))
    else $error("reboot did not save and detach first");
  a_pins_tristate_off: assert property (!interface_supply |-> !digital_oe)
    else $error("digital pins driven while interface supply off");
  a_backup_kept: assert property (main_supply [*8] |-> backup_supply)
    else $error("backup supply off with main supply present");
  a_no_take_off: assert property (!interface_supply |-> !cmd_ready)
    else $error("command accepted while powered off");
  a_key_waits_release: assert property ((interface_supply && !power_key_n && main_supply && hard_reset_n) [*6]
    |=> interface_supply)
    else $error("switched off before power key release");
  a_long_key_acts: assert property ($rose(power_key_n) && key_cnt_ff >= 8'h14 && cmd_ready
    |-> ##[1:10] !cmd_ready)
    else $error("long key pulse did not start switch-off");

  // main scenarios reached
  c_take_off: cover property (take_off);
  c_take_reboot: cover property (take_reboot);
  c_long_key: cover property ($rose(power_key_n) && key_cnt_ff >= 8'h14);
endmodule

// ===== verif/tb.sv
/*
  testbench: host and device joined by one link, plus a second device
  driven by the bench itself to break the host's side on purpose.
  assumes package, link interface and both ends are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] op;
    logic save;
    logic reboot;
    logic up;
    logic pwr;
  } mpsq_row_s;

  logic i_clock, i_srst, thermal_en, temp_danger;
  logic [4:0] req;
  logic busy, supply, up, forced;
  logic run1, save1, det1, reb1, abr1, run2, save2, det2, reb2, abr2;
  logic sv1, rb1, sv2, ab2, dt1, dt2, fr;
  int err_count, num_checks;
  // op 1 switch-off, 2 reboot, 3 key pulse, 4 thermal shutdown; pwr: host still supplies
  mpsq_row_s rows [4] = '{'{3'h1, 1'b1, 1'b0, 1'b0, 1'b0}, '{3'h2, 1'b1, 1'b1, 1'b1, 1'b1},
                         '{3'h3, 1'b1, 1'b0, 1'b0, 1'b1}, '{3'h4, 1'b1, 1'b0, 1'b0, 1'b1}};

  // ---------------------------------------------------------------
  // ends under test
  // ---------------------------------------------------------------
  mpsq_link_if link1 ();
  mpsq_link_if link2 ();
  mpsq_host u_mpsq_host (.i_clock(i_clock), .i_srst(i_srst), .link(link1), .i_supply_on(req[0]),
    .i_switch_off(req[1]), .i_reboot(req[2]), .i_key_pulse(req[3]), .i_thermal_set(req[4]),
    .i_thermal_en(thermal_en), .o_busy(busy), .o_supply(supply), .o_device_up(up), .o_forced_reset(forced));
  mpsq_device u_mpsq_device (.i_clock(i_clock), .i_srst(i_srst), .link(link1), .i_temp_danger(temp_danger),
    .o_running(run1), .o_saving(save1), .o_detaching(det1), .o_reboot_pulse(reb1), .o_abrupt_pulse(abr1));
  // second device: the bench stands in for the host
  mpsq_device u_mpsq_device_b (.i_clock(i_clock), .i_srst(i_srst), .link(link2), .i_temp_danger(1'b0),
    .o_running(run2), .o_saving(save2), .o_detaching(det2), .o_reboot_pulse(reb2), .o_abrupt_pulse(abr2));
  mpsq_link_properties u_mpsq_link_properties (.i_clock(i_clock), .i_srst(i_srst),
    .power_key_n(link1.power_key_n), .hard_reset_n(link1.hard_reset_n), .main_supply(link1.main_supply),
    .interface_supply(link1.interface_supply), .backup_supply(link1.backup_supply),
    .digital_oe(link1.digital_oe), .cmd_valid(link1.cmd_valid), .cmd_code(link1.cmd_code),
    .cmd_ready(link1.cmd_ready), .rsp_ok(link1.rsp_ok));

  // 40 mhz clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // step past edges, gathering one-cycle flags so pulses are not missed
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #2;
      sv1 |= save1;
      rb1 |= reb1;
      sv2 |= save2;
      ab2 |= abr2;
      dt1 |= det1;
      dt2 |= det2;
      fr |= forced;
    end
  endtask

  task automatic check(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return up;
      1: return ~busy;
      default: return run2;
    endcase
  endfunction

  // bounded wait; running out ends the run as a failure
  task automatic wait_for(input int w, input int lim);
    int k;
    k = 0;
    while (pick(w) !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    if (pick(w) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", w);
      give_verdict();
    end
  endtask

  // one-cycle user request, only once the host is idle
  task automatic pulse(input int which);
    wait_for(1, 600);
    req = 5'h01 << which;
    tick(1);
    req = 5'h00;
  endtask

  // supply first; a key pulse too if supply alone does not boot
  task automatic bring_up();
    if (up !== 1'b1) begin
      pulse(0);
      tick(300);
      if (up !== 1'b1) begin
        pulse(3);
      end
      wait_for(0, 400);
    end
  endtask

  task automatic key2(input int n);
    link2.power_key_oe = 1'b1;
    tick(n);
    link2.power_key_oe = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {req, thermal_en, temp_danger, sv1, rb1, sv2, ab2, dt1, dt2, fr} = '0;
    {link2.power_key_oe, link2.hard_reset_oe, link2.main_supply, link2.cmd_valid, link2.cmd_arg} = '0;
    link2.cmd_code = mpsq_pkg::CMD_NONE;
    err_count = 0;
    num_checks = 0;
    i_srst = 1'b1;
    tick(3);
    check("reset interface supply", 1'b0, link1.interface_supply);
    check("reset cmd ready", 1'b0, link1.cmd_ready);
    check("reset host supply", 1'b0, supply);
    i_srst = 1'b0;
    thermal_en = 1'b1;
    // ordinary flows through the host end
    foreach (rows[i]) begin
      bring_up();
      wait_for(1, 600);
      sv1 = 1'b0;
      rb1 = 1'b0;
      dt1 = 1'b0;
      pulse(int'(rows[i].op));
      if (rows[i].op == 3'h4) begin
        wait_for(1, 600);
        temp_danger = 1'b1;
      end
      tick(250);
      temp_danger = 1'b0;
      check("saving seen", rows[i].save, sv1);
      check("reboot pulse", rows[i].reboot, rb1);
      check("device up", rows[i].up, up);
      check("detach seen", rows[i].save, dt1);
      check("host supply", rows[i].pwr, supply);
    end
    // danger while supervision is disabled must be ignored
    bring_up();
    thermal_en = 1'b0;
    pulse(4);
    wait_for(1, 600);
    temp_danger = 1'b1;
    tick(80);
    temp_danger = 1'b0;
    check("thermal off running", 1'b1, run1);
    check("no forced reset", 1'b0, fr);
    // second device: bring it to running
    link2.main_supply = 1'b1;
    tick(60);
    if (run2 !== 1'b1) begin
      key2(21);
    end
    wait_for(2, 400);
    // short key pulse is ignored
    sv2 = 1'b0;
    key2(8);
    tick(60);
    check("short key running", 1'b1, run2);
    check("short key no save", 1'b0, sv2);
    // hard reset low while running: abrupt stop, nothing saved
    ab2 = 1'b0;
    dt2 = 1'b0;
    link2.hard_reset_oe = 1'b1;
    tick(40);
    check("reset abrupt", 1'b1, ab2);
    check("reset no save", 1'b0, sv2);
    check("reset no detach", 1'b0, dt2);
    check("reset supply off", 1'b0, link2.interface_supply);
    check("reset pins off", 1'b0, link2.digital_oe);
    check("backup kept", 1'b1, link2.backup_supply);
    link2.hard_reset_oe = 1'b0;
    wait_for(2, 400);
    // supply loss while running
    ab2 = 1'b0;
    link2.main_supply = 1'b0;
    tick(10);
    check("loss abrupt", 1'b1, ab2);
    check("loss no save", 1'b0, sv2);
    check("loss no detach", 1'b0, dt2);
    check("loss supply off", 1'b0, link2.interface_supply);
    // a command offered while off is never taken
    link2.cmd_code = mpsq_pkg::CMD_SWITCH_OFF;
    link2.cmd_valid = 1'b1;
    tick(30);
    check("off cmd ready", 1'b0, link2.cmd_ready);
    check("off no answer", 1'b0, link2.rsp_ok);
    link2.cmd_valid = 1'b0;
    give_verdict();
  end
endmodule
